// file: gate_driver_fault_protection_tb_top.sv
`timescale 1ns/1ns
`include "gdfp_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end
module gate_driver_fault_protection_tb_top
  import gdfp_pkg::*;
;
  typedef struct packed {logic rd; logic [31:0] m; logic [31:0] v;} note_t;
  logic sys_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, probe = 0, slow = 0;
  logic pumpBelowHi = 0, pumpBelowLo = 0, hotWarnCmp = 0, hotShutCmp = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, lfsr = 32'h67D4ED01, cur = '0, prdata;
  logic [7:0] dsOverCmp = '0, gateDriveOn = '0, pwmIn = '0, stuck = '0, pd, gateCrossed;
  logic [7:0] gatePullDown, switch_node_pullup_en, switch_node_pulldown_en;
  logic [3:0] activeSinkCurrent, overcurrentThreshold;
  logic pready, pslverr, alarm_pin_n, faultSummary, warnSummary, bridge_fault_summary;
  logic pumpEnable, pumpThresholdHigh;
  logic [2:0] thresholdPinLevel = 3'h0, ch;
  logic [1:0] brgTab [5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
  logic indTab [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic [31:0] MO = 32'hE800FF00;
  int fail_count = 0, compares = 0;
  note_t q[$], n;
  wire [31:0] obs = {alarm_pin_n, faultSummary, warnSummary, bridge_fault_summary, pumpEnable,
                     3'h0, activeSinkCurrent, overcurrentThreshold, gatePullDown,
                     switch_node_pullup_en};
  always #20 sys_clk = ~sys_clk;
  gate_fault_protect #(.NCH(8), .PIN_CFG(1'b0)) i_gate_fault_protect (
    .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .pumpBelowHi, .pumpBelowLo, .dsOverCmp, .gateCrossed, .gateDriveOn, .pwmIn, .hotWarnCmp,
    .hotShutCmp, .thresholdPinLevel, .alarm_pin_n, .faultSummary, .warnSummary,
    .bridge_fault_summary, .gatePullDown, .pumpEnable, .activeSinkCurrent, .pumpThresholdHigh,
    .overcurrentThreshold, .switch_node_pullup_en, .switch_node_pulldown_en);
  half_bridge_model #(.NCH(8), .RISE(3)) i_half_bridge_model (
    .sys_clk, .slow, .gateDriveOn, .gatePullDown, .stuck, .gateCrossed);
  always @(posedge sys_clk) begin
    if ((psel && penable && !pwrite && pready) || probe) begin
      n = q.pop_front();
      `CHK((n.rd ? prdata : obs) & n.m, n.v & n.m)
    end
    // every access: only unmapped addresses answer with an error
    if (psel && penable && pready) begin
      `CHK(pslverr, paddr > `REG_CHANFLAGS)
    end
  end
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function logic [31:0] ob(input logic a, f, w, p, input logic [7:0] g);
    return {a, f, w, 1'b0, p, 11'h0, g, 8'h0};
  endfunction
  task results;
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge sys_clk) penable <= 1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin fail_count++; results(); end
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, v);
    q.push_back('{1'b1, m, v});
    apb(1'b0, a, 32'h0);
  endtask
  task chk(input logic [31:0] m, v);
    q.push_back('{1'b0, m, v});
    @(posedge sys_clk) probe <= 1;
    @(posedge sys_clk) probe <= 0;
  endtask
  task setcfg(input logic [1:0] oc, gf, brg, input logic ind, auto);
    // random deglitch select: the 300-cycle wait and the 600-cycle alarm timeout outlast the longest one
    cur = {4'h0, 8'h5A, 2'h0, brg, ind, gf, ind, 4'h7, 2'(rnd()), oc, 1'b0, auto, 2'h2};
    apb(1'b1, `REG_CONFIG, cur);
  endtask
  task clr;
    apb(1'b1, `REG_CONFIG, cur | 32'h1);
    repeat (2) @(posedge sys_clk);
  endtask
  task waital(input logic lvl);
    int k;
    k = 0;
    while (alarm_pin_n !== lvl && k < 600) begin @(posedge sys_clk); k++; end
    if (k >= 600) begin fail_count++; results(); end
  endtask
  task pump(input logic v);
    pumpBelowLo <= v;
    pumpBelowHi <= v;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst_b <= 1;
    chk(MO, ob(1, 0, 0, 1, 8'hFF));
    rd(12'h010, 32'hFFFFFFFF, 32'h0);
    setcfg(2'h3, 2'h3, 2'h0, 1'b0, 1'b1);
    pump(1); waital(0);
    chk(MO, ob(0, 1, 0, 1, 8'hFF));
    pump(0); waital(1);
    rd(`REG_STATUS, 32'h12, 32'h10);
    clr; rd(`REG_STATUS, 32'h10, 32'h0);
    setcfg(2'h3, 2'h3, 2'h0, 1'b0, 1'b0);
    pump(1); waital(0);
    clr; chk(MO, ob(0, 1, 0, 0, 8'hFF));
    pump(0); repeat (5) @(posedge sys_clk);
    chk(MO, ob(0, 1, 0, 0, 8'hFF));
    clr; chk(MO, ob(1, 0, 0, 1, 8'h0));
    for (int i = 0; i < 5; i++) begin
      ch = 3'(rnd());
      setcfg(2'h0, 2'h3, brgTab[i], indTab[i], 1'b1);
      pd = !indTab[i] ? 8'hFF : (brgTab[i] inside {2'h1, 2'h2}) ? 8'h3 << {ch[2:1], 1'b0}
                                                                 : 8'h1 << ch;
      dsOverCmp[ch] <= 1; waital(0);
      chk(MO | 32'h00F00000, ob(0, 1, 0, 1, pd) | 32'h00A00000);
      dsOverCmp <= '0; repeat (3) @(posedge sys_clk);
      chk(MO | 32'h10000000, ob(0, 1, 0, 1, pd) | 32'h10000000);
      rd(`REG_CHANFLAGS, 32'hFF, 32'h1 << ch);
      clr; rd(`REG_CHANFLAGS, 32'hFF, 32'h0);
    end
    for (int k = 0; k < 2; k++) for (int m = 0; m < 4; m++) begin
      ch = 3'(rnd());
      slow <= lfsr[7];
      if (k == 0) setcfg(2'(m), 2'h3, 2'h0, 1'b1, 1'b1);
      else setcfg(2'h3, 2'(m), 2'h0, 1'b1, 1'b1);
      gateDriveOn[ch] <= 1;
      if (k == 0) dsOverCmp[ch] <= 1;
      else stuck[ch] <= 1;
      repeat (300) @(posedge sys_clk);
      chk(MO, ob(m > 1, m < 2, m == 2, 1, m < 2 ? 8'h1 << ch : 8'h0));
      rd(`REG_CHANFLAGS, 32'hFF00FF, m == 3 ? 32'h0 : (k ? 32'h10000 : 32'h1) << ch);
      dsOverCmp <= '0; stuck <= '0; gateDriveOn <= '0;
      if (m == 1) pwmIn <= ~pwmIn;
      repeat (5) @(posedge sys_clk);
      chk(MO, ob(m != 0, m == 0, m == 2, 1, m == 0 ? 8'h1 << ch : 8'h0));
      clr; rd(`REG_CHANFLAGS, 32'hFF00FF, 32'h0);
    end
    setcfg(2'h3, 2'h3, 2'h0, 1'b0, 1'b1);
    hotWarnCmp <= 1; repeat (5) @(posedge sys_clk);
    hotWarnCmp <= 0; repeat (2) @(posedge sys_clk);
    rd(`REG_STATUS, 32'h24, 32'h24);
    clr; rd(`REG_STATUS, 32'h24, 32'h0);
    hotShutCmp <= 1; waital(0);
    hotShutCmp <= 0; repeat (5) @(posedge sys_clk);
    chk(MO, ob(0, 1, 0, 0, 8'hFF));
    rd(`REG_STATUS, 32'h40, 32'h40);
    clr; chk(MO, ob(1, 0, 0, 1, 8'h0));
    cur = (cur & 32'hFFFFF0FD) | 32'h800;
    apb(1'b1, `REG_CONFIG, cur);
    apb(1'b1, `REG_DIAG, 32'h00A55A00);
    chk(32'hFF, 32'h0);
    apb(1'b1, `REG_DIAG, 32'h00A55A01);
    chk(32'h000F00FF, 32'h0008005A);
    dsOverCmp <= 8'(rnd()); repeat (4) @(posedge sys_clk);
    rd(`REG_CHANFLAGS, 32'hFF, {24'h0, dsOverCmp});
    chk(32'h58000000, 32'h08000000);
    dsOverCmp <= '0; repeat (2) @(posedge sys_clk);
    apb(1'b1, `REG_DIAG, 32'h0);
    chk(32'hFF, 32'h0);
    results();
  end
endmodule

// file: gate_fault_protect.sv
// How it works
// - pump below level past deglitch: pull gates down, alarm, summary, pump-low flag
// - latched pump mode: also stop pump; hold all until clear command
// - auto pump mode: alarm and summary drop when condition ends; flag stays
// - pin-configured variant: auto recovery and fixed 2 V pump threshold
// - overcurrent flagged after comparator exceeds selected level past selected deglitch
// - modes 00b/11b: independence picks all half-bridges or only the faulting one
// - modes 01b/10b: independence picks all H-bridges or only the faulting one
// - latched overcurrent: pull down, alarm, summary, channel flag held until clear
// - cycle mode: as latched, next pwm edge releases alarm and driver
// - warning-only overcurrent: warning summary and channel flag only, held until clear
// - disabled overcurrent: no reaction and no report
// - pin variant: cycle mode, 4 us deglitch, per-bridge shutdown, level 6 disables
// - overcurrent turnoff uses its own sink setting; pin variant uses normal sink
// - gate fault when gate does not cross level within drive time
// - gate-fault independence: per half-bridge or per H-bridge by control mode
// - gate-fault modes latched, cycle, warning, disabled; flag held until clear
// - pin variant: gate fault cycle mode, 4 us drive time, level 6 disables
// - thermal warning sets warning summary and hot flag until clear; none on pins
// - thermal shutdown pulls down, stops pump, alarms; latched, pins auto-recover
// - switch-node current sources applied only while diagnostics enabled
// - diagnostics mirror live overcurrent comparators in channel flags, warning and bridge summaries stay quiet
// - clear command clears latched state and flags, then self-clears
`timescale 1ns/1ns
`include "gdfp_cfg.svh"
module gate_fault_protect
  import gdfp_pkg::*;
#(
  parameter int NCH      = 8,
  parameter bit PIN_CFG  = 1'b0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic [31:0]           prdata,
  output logic                  pslverr,
  input  wire logic             pumpBelowHi,
  input  wire logic             pumpBelowLo,
  input  wire logic [NCH-1:0]   dsOverCmp,
  input  wire logic [NCH-1:0]   gateCrossed,
  input  wire logic [NCH-1:0]   gateDriveOn,
  input  wire logic [NCH-1:0]   pwmIn,
  input  wire logic             hotWarnCmp,
  input  wire logic             hotShutCmp,
  input  wire logic [2:0]       thresholdPinLevel,
  output logic                  alarm_pin_n,
  output logic                  faultSummary,
  output logic                  warnSummary,
  output logic                  bridge_fault_summary,
  output logic [NCH-1:0]        gatePullDown,
  output logic                  pumpEnable,
  output logic [3:0]            activeSinkCurrent,
  output logic                  pumpThresholdHigh,
  output logic [3:0]            overcurrentThreshold,
  output logic [NCH-1:0]        switch_node_pullup_en,
  output logic [NCH-1:0]        switch_node_pulldown_en
);

  localparam int PUMP_DG = (`PUMP_DG_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int DGW     = $clog2(((`DG_NS3 + `CLK_NS - 1) / `CLK_NS) + 2);

  typedef struct packed {
    cfg_t             cfg;
    misc_t            m;
    logic [NCH-1:0]   puEn;
    logic [NCH-1:0]   pdEn;
    logic [NCH-1:0]   ocFlag;
    logic [NCH-1:0]   gfFlag;
    logic [NCH-1:0]   ocTrip;
    logic [NCH-1:0]   gfTrip;
    logic [NCH-1:0]   ocWarn;
    logic [NCH-1:0]   gfWarn;
    logic [NCH-1:0]   pwmPrev;
    logic [NCH*DGW-1:0] ocCnt;
    logic [NCH*DGW-1:0] gfCnt;
    logic [15:0]      pumpCnt;
  } state_t;

  state_t s_r, s_nxt;

  // deglitch selection to whole cycles, any partial cycle rounds up
  function automatic logic [DGW-1:0] dgCycles(input logic [1:0] sel);
    int ns;
    case (sel)
      2'h0:    ns = `DG_NS0;
      2'h1:    ns = `DG_NS1;
      2'h2:    ns = `DG_NS2;
      default: ns = `DG_NS3;
    endcase
    dgCycles = DGW'((ns + `CLK_NS - 1) / `CLK_NS);
  endfunction

  // mask of channels shut down by a trip on channel ch
  function automatic logic [NCH-1:0] shutMask(input int ch, input logic ind,
                                              input logic [1:0] brg);
    shutMask = '0;
    if (!ind) begin
      shutMask = '1;
    end else if (brg == `BRG_PHEN || brg == `BRG_PWM) begin
      shutMask[ch & ~1] = 1'b1;
      shutMask[ch | 1]  = 1'b1;
    end else begin
      shutMask[ch] = 1'b1;
    end
  endfunction

  logic         pinOff;
  logic [1:0]   ocMode;
  logic [1:0]   gfMode;
  logic [1:0]   dgSel;
  logic         ocIndEff;
  logic         gfIndEff;
  logic         pumpAuto;
  logic         pumpCond;
  logic         wrEn;
  logic         rdEn;
  logic         known;
  logic [NCH-1:0] pwmEdge;
  logic [NCH-1:0] pullMask;
  logic [NCH-1:0] ocPullMask;
  logic [31:0]  rd;

  always_comb begin
    pinOff   = PIN_CFG && (thresholdPinLevel == `HW_OFF_LEVEL);
    ocMode   = PIN_CFG ? (pinOff ? `MODE_OFF : `MODE_CYCLE) : s_r.cfg.ocResp;
    gfMode   = PIN_CFG ? (pinOff ? `MODE_OFF : `MODE_CYCLE) : s_r.cfg.gfResp;
    dgSel    = PIN_CFG ? `HW_DG_SEL : s_r.cfg.ocDg;
    ocIndEff = PIN_CFG ? 1'b1 : s_r.cfg.ocInd;
    gfIndEff = PIN_CFG ? 1'b1 : s_r.cfg.gfInd;
    pumpAuto = PIN_CFG ? 1'b1 : s_r.cfg.pumpLowResp;
    pumpCond = (PIN_CFG ? `HW_PUMP_TH : s_r.cfg.pumpLowThr) ? pumpBelowHi : pumpBelowLo;
    wrEn     = psel && penable && pwrite;
    rdEn     = psel && !penable && !pwrite;
    known    = paddr == `REG_CONFIG || paddr == `REG_DIAG ||
               paddr == `REG_STATUS || paddr == `REG_CHANFLAGS;
    pwmEdge  = pwmIn ^ s_r.pwmPrev;
    s_nxt    = s_r;
    s_nxt.pwmPrev = pwmIn;
    s_nxt.cfg.clearCmd = 1'b0;

    // charge pump deglitch
    if (!pumpCond) begin
      s_nxt.pumpCnt = '0;
    end else if (s_r.pumpCnt < 16'(PUMP_DG)) begin
      s_nxt.pumpCnt = s_r.pumpCnt + 16'h0001;
    end
    if (s_nxt.pumpCnt >= 16'(PUMP_DG)) begin
      s_nxt.m.pumpLowFlag = 1'b1;
      s_nxt.m.pumpActive  = 1'b1;
      if (!pumpAuto) begin
        s_nxt.m.pumpLatched = 1'b1;
      end
    end else begin
      s_nxt.m.pumpActive = 1'b0;
    end

    // per-channel overcurrent and gate-fault monitors
    for (int c = 0; c < NCH; c++) begin
      logic [DGW-1:0] oc;
      logic [DGW-1:0] gf;
      oc = s_r.ocCnt[c*DGW +: DGW];
      gf = s_r.gfCnt[c*DGW +: DGW];
      oc = dsOverCmp[c] ? ((oc < dgCycles(dgSel)) ? oc + 1'b1 : oc) : '0;
      gf = (gateDriveOn[c] && !gateCrossed[c]) ?
           ((gf < dgCycles(dgSel)) ? gf + 1'b1 : gf) : '0;
      s_nxt.ocCnt[c*DGW +: DGW] = oc;
      s_nxt.gfCnt[c*DGW +: DGW] = gf;
      if (s_r.m.diagEn) begin
        s_nxt.ocFlag[c] = dsOverCmp[c];
      end else if (oc >= dgCycles(dgSel) && ocMode != `MODE_OFF) begin
        s_nxt.ocFlag[c] = 1'b1;
        if (ocMode == `MODE_WARN) begin
          s_nxt.ocWarn[c] = 1'b1;
        end else begin
          s_nxt.ocTrip[c] = 1'b1;
        end
      end
      if (gf >= dgCycles(dgSel) && gfMode != `MODE_OFF && !s_r.m.diagEn) begin
        s_nxt.gfFlag[c] = 1'b1;
        if (gfMode == `MODE_WARN) begin
          s_nxt.gfWarn[c] = 1'b1;
        end else begin
          s_nxt.gfTrip[c] = 1'b1;
        end
      end
      // cycle mode: a new pwm edge releases the trip, flag stays
      if (pwmEdge[c] && ocMode == `MODE_CYCLE && !dsOverCmp[c]) begin
        s_nxt.ocTrip[c] = 1'b0;
      end
      if (pwmEdge[c] && gfMode == `MODE_CYCLE && gf < dgCycles(dgSel)) begin
        s_nxt.gfTrip[c] = 1'b0;
      end
    end

    // thermal
    if (hotWarnCmp && !PIN_CFG) begin
      s_nxt.m.hotWarn = 1'b1;
    end
    s_nxt.m.shutFlag = hotShutCmp || (s_r.m.shutFlag && !PIN_CFG);
    if (hotShutCmp && !PIN_CFG) begin
      s_nxt.m.shutLatched = 1'b1;
    end

    // clear command: set wins when the condition persists
    if (s_r.cfg.clearCmd) begin
      s_nxt.m.pumpLowFlag = s_nxt.m.pumpActive;
      s_nxt.m.pumpLatched = s_nxt.m.pumpActive && !pumpAuto;
      s_nxt.m.hotWarn     = hotWarnCmp && !PIN_CFG;
      s_nxt.m.shutFlag    = hotShutCmp;
      s_nxt.m.shutLatched = hotShutCmp && !PIN_CFG;
      for (int c = 0; c < NCH; c++) begin
        if (!dsOverCmp[c] || s_r.m.diagEn) begin
          s_nxt.ocTrip[c] = 1'b0;
          s_nxt.ocWarn[c] = 1'b0;
          if (!s_r.m.diagEn) begin
            s_nxt.ocFlag[c] = 1'b0;
          end
        end
        if (s_nxt.gfCnt[c*DGW +: DGW] < dgCycles(dgSel)) begin
          s_nxt.gfTrip[c] = 1'b0;
          s_nxt.gfWarn[c] = 1'b0;
          s_nxt.gfFlag[c] = 1'b0;
        end
      end
    end

    // apb register writes, taken in the access phase
    if (wrEn) begin
      unique case (paddr)
        `REG_CONFIG: begin
          s_nxt.cfg.clearCmd     = pwdata[0];
          s_nxt.cfg.driverEnable = pwdata[1];
          s_nxt.cfg.pumpLowResp  = pwdata[2];
          s_nxt.cfg.pumpLowThr   = pwdata[3];
          s_nxt.cfg.ocResp       = pwdata[5:4];
          s_nxt.cfg.ocDg         = pwdata[7:6];
          s_nxt.cfg.ocThr        = pwdata[11:8];
          s_nxt.cfg.ocInd        = pwdata[12];
          s_nxt.cfg.gfResp       = pwdata[14:13];
          s_nxt.cfg.gfInd        = pwdata[15];
          s_nxt.cfg.brgMode      = pwdata[17:16];
          s_nxt.cfg.ocSink       = pwdata[23:20];
          s_nxt.cfg.sinkSetting  = pwdata[27:24];
        end
        `REG_DIAG: begin
          // diagnostics exist only on register-configured parts
          s_nxt.m.diagEn = pwdata[0] && !PIN_CFG;
          s_nxt.puEn     = pwdata[8 +: NCH];
          s_nxt.pdEn     = pwdata[16 +: NCH];
        end
        default: begin
        end
      endcase
    end

    // read data registered in setup so it stands during access
    rd = 32'h0000_0000;
    unique case (paddr)
      `REG_CONFIG:    rd = {4'h0, s_r.cfg.sinkSetting, s_r.cfg.ocSink, 2'h0,
                            s_r.cfg.brgMode, s_r.cfg.gfInd, s_r.cfg.gfResp,
                            s_r.cfg.ocInd, s_r.cfg.ocThr, s_r.cfg.ocDg,
                            s_r.cfg.ocResp, s_r.cfg.pumpLowThr, s_r.cfg.pumpLowResp,
                            s_r.cfg.driverEnable, s_r.cfg.clearCmd};
      `REG_DIAG:      rd = {8'h00, 8'(s_r.pdEn), 8'(s_r.puEn), 7'h00, s_r.m.diagEn};
      `REG_STATUS:    rd = {25'h0, s_r.m.shutFlag, s_r.m.hotWarn, s_r.m.pumpLowFlag,
                            bridge_fault_summary, warnSummary, faultSummary,
                            s_r.m.pumpLatched};
      `REG_CHANFLAGS: rd = {8'h00, 8'(s_r.gfFlag), 8'h00, 8'(s_r.ocFlag)};
      default:        rd = 32'h0000_0000;
    endcase
    if (rdEn) begin
      s_nxt.m.rdata = rd;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // shutdown masks and outputs
  logic anyTrip;
  logic pumpFault;
  always_comb begin
    ocPullMask = '0;
    pullMask   = '0;
    for (int c = 0; c < NCH; c++) begin
      if (s_r.ocTrip[c]) begin
        ocPullMask = ocPullMask | shutMask(c, ocIndEff, s_r.cfg.brgMode);
      end
      if (s_r.gfTrip[c]) begin
        pullMask = pullMask | shutMask(c, gfIndEff, s_r.cfg.brgMode);
      end
    end
    pumpFault = s_r.m.pumpActive || s_r.m.pumpLatched;
    anyTrip   = pumpFault || s_r.m.shutFlag || (|s_r.ocTrip) || (|s_r.gfTrip);
    if (pumpFault || s_r.m.shutFlag || !(PIN_CFG || s_r.cfg.driverEnable)) begin
      pullMask = '1;
    end
    pullMask = pullMask | ocPullMask;
  end

  assign gatePullDown         = pullMask;
  assign faultSummary         = anyTrip;
  assign alarm_pin_n          = !anyTrip;
  assign warnSummary          = !s_r.m.diagEn && ((|s_r.ocWarn) || (|s_r.gfWarn) ||
                                s_r.m.hotWarn);
  assign bridge_fault_summary = !s_r.m.diagEn && ((|s_r.ocFlag) || (|s_r.gfFlag));
  assign pumpEnable           = !s_r.m.pumpLatched && !s_r.m.shutFlag;
  assign activeSinkCurrent    = ((|ocPullMask) && !PIN_CFG) ? s_r.cfg.ocSink
                                                            : s_r.cfg.sinkSetting;
  assign pumpThresholdHigh    = PIN_CFG ? `HW_PUMP_TH : s_r.cfg.pumpLowThr;
  assign overcurrentThreshold = s_r.cfg.ocThr;
  assign switch_node_pullup_en   = s_r.m.diagEn ? s_r.puEn : '0;
  assign switch_node_pulldown_en = s_r.m.diagEn ? s_r.pdEn : '0;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;
  assign prdata  = s_r.m.rdata;

endmodule

// file: gate_fault_protect_checker.sv
`timescale 1ns/1ns
`include "gdfp_cfg.svh"
module gate_fault_protect_checker
  import gdfp_pkg::*;
#(
  parameter int NCH = 8
) (
  input wire logic           sys_clk,
  input wire logic           rst_b,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic           pumpBelowHi,
  input wire logic           pumpBelowLo,
  input wire logic [NCH-1:0] dsOverCmp,
  input wire logic [NCH-1:0] pwmIn,
  input wire logic           hotShutCmp,
  input wire logic           alarm_pin_n,
  input wire logic           faultSummary,
  input wire logic           bridge_fault_summary,
  input wire logic [NCH-1:0] gatePullDown,
  input wire logic           pumpEnable,
  input wire logic [3:0]     activeSinkCurrent,
  input wire logic           pumpThresholdHigh,
  input wire logic [3:0]     overcurrentThreshold,
  input wire logic [NCH-1:0] switch_node_pullup_en,
  input wire logic [NCH-1:0] switch_node_pulldown_en
);
  logic [31:0] cfg_r;
  logic        diag_r;
  logic [8:0]  pumpCnt_r;
  logic [8:0]  ocCnt_r;
  logic [8:0]  dgCyc;
  logic        pumpLow;
  assign dgCyc = 9'h019 << cfg_r[7:6];
  assign pumpLow = pumpThresholdHigh ? pumpBelowHi : pumpBelowLo;
  // shadow of the written config, since the checker sees ports only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_r <= '0;
      diag_r <= 1'b0;
      pumpCnt_r <= '0;
      ocCnt_r <= '0;
    end else begin
      if (psel && penable && pwrite && paddr == `REG_CONFIG) cfg_r <= pwdata;
      if (psel && penable && pwrite && paddr == `REG_DIAG) diag_r <= pwdata[0];
      pumpCnt_r <= !pumpLow ? 9'h0 : pumpCnt_r + 9'(pumpCnt_r != 9'h1FF);
      ocCnt_r <= dsOverCmp == '0 ? 9'h0 : ocCnt_r + 9'(ocCnt_r != 9'h1FF);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_alarm_vs_fault: assert property (alarm_pin_n == !faultSummary)
    else $error("alarm pin and fault summary disagree");
  a_pump_trip_bound: assert property (pumpCnt_r == 9'h100 |-> !alarm_pin_n)
    else $error("pump low past deglitch without alarm");
  a_pump_off_alarm: assert property (!pumpEnable |-> !alarm_pin_n)
    else $error("pump stopped without alarm");
  a_sources_need_diag: assert property (!diag_r |->
    switch_node_pullup_en == '0 && switch_node_pulldown_en == '0)
    else $error("current source on outside diagnostics");
  a_diag_quiet: assert property (diag_r && $past(diag_r) |-> !$rose(bridge_fault_summary))
    else $error("bridge summary raised during diagnostics");
  a_sink_idle: assert property (gatePullDown == '0 |-> activeSinkCurrent == cfg_r[27:24])
    else $error("sink current wrong while no pulldown");
  a_thr_config: assert property (overcurrentThreshold == cfg_r[11:8] &&
    pumpThresholdHigh == cfg_r[3])
    else $error("threshold outputs differ from config");
  a_oc_trip_bound: assert property ((ocCnt_r == dgCyc + 9'h004 && cfg_r[5:4] < 2'h2 &&
    cfg_r[1] && !diag_r) |-> !alarm_pin_n)
    else $error("overcurrent past deglitch without alarm");
  a_cycle_release: assert property ((cfg_r[5:4] == 2'h1 && cfg_r[14:13] == 2'h3 &&
    cfg_r[2] && !alarm_pin_n && pwmIn != $past(pwmIn) && dsOverCmp == '0 &&
    pumpCnt_r == '0 && !hotShutCmp) |-> ##[1:3] alarm_pin_n)
    else $error("pwm edge did not release cycle trip");
  c_pump_stop: cover property ($fell(pumpEnable));
  c_diag_src: cover property (diag_r && switch_node_pullup_en != '0);
  c_oc_trip: cover property (ocCnt_r == 9'h01E && !alarm_pin_n);
endmodule
bind gate_fault_protect gate_fault_protect_checker #(.NCH(NCH)) i_gate_fault_protect_checker (
  .sys_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pumpBelowHi, .pumpBelowLo,
  .dsOverCmp, .pwmIn, .hotShutCmp, .alarm_pin_n, .faultSummary, .bridge_fault_summary,
  .gatePullDown, .pumpEnable, .activeSinkCurrent, .pumpThresholdHigh, .overcurrentThreshold,
  .switch_node_pullup_en, .switch_node_pulldown_en);

// file: gdfp_cfg.svh
`ifndef GDFP_CFG_SVH
`define GDFP_CFG_SVH

// apb register byte offsets
`define REG_CONFIG     12'h000
`define REG_DIAG       12'h004
`define REG_STATUS     12'h008
`define REG_CHANFLAGS  12'h00C

// response mode encodings
`define MODE_LATCH     2'h0
`define MODE_CYCLE     2'h1
`define MODE_WARN      2'h2
`define MODE_OFF       2'h3

// bridge control modes
`define BRG_HALF       2'h0
`define BRG_PHEN       2'h1
`define BRG_PWM        2'h2
`define BRG_SPLIT      2'h3

// fixed settings for pin-configured variants, then the clock period in ns
`define HW_DG_NS       4000
`define HW_DG_SEL      2'h2
`define HW_OFF_LEVEL   3'h6
`define HW_PUMP_TH     1'h0
`define CLK_NS         40

// deglitch times in ns: four selectable by register, then the fixed pump one
`define DG_NS0         1000
`define DG_NS1         2000
`define DG_NS2         4000
`define DG_NS3         8000
`define PUMP_DG_NS     10000

`endif

// file: gdfp_pkg.sv
package gdfp_pkg;
  typedef struct packed {
    logic       clearCmd;
    logic       driverEnable;
    logic       pumpLowResp;
    logic       pumpLowThr;
    logic [1:0] ocResp;
    logic [1:0] ocDg;
    logic [3:0] ocThr;
    logic       ocInd;
    logic [1:0] gfResp;
    logic       gfInd;
    logic [1:0] brgMode;
    logic [3:0] ocSink;
    logic [3:0] sinkSetting;
  } cfg_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        pumpLowFlag;
    logic        pumpLatched;
    logic        pumpActive;
    logic        hotWarn;
    logic        shutFlag;
    logic        shutLatched;
    logic        diagEn;
  } misc_t;
endpackage

// file: half_bridge_model.sv
`timescale 1ns/1ns
module half_bridge_model #(
  parameter int NCH  = 8,
  parameter int RISE = 3
) (
  input  wire logic           sys_clk,
  input  wire logic           slow,
  input  wire logic [NCH-1:0] gateDriveOn,
  input  wire logic [NCH-1:0] gatePullDown,
  input  wire logic [NCH-1:0] stuck,
  output logic      [NCH-1:0] gateCrossed
);
  // slow gates still cross inside the shortest drive window of 25 cycles
  int cnt [NCH];
  always @(posedge sys_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (!gateDriveOn[i] || gatePullDown[i] || stuck[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] < (slow ? 20 : RISE)) begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      gateCrossed[i] = cnt[i] >= (slow ? 20 : RISE);
    end
  end
endmodule
